//--- bfc_codec.sv
`default_nettype none
`include "bfc_map.svh"
// Operation
// - Option byte selects XOR check, rest zero
// - Frame: node, control, count, payload, check
// - Header and check bytes always present
// - Node byte: target 7..5, source 3..1
// - Only address pair zero supported
// - First valid received frame opens connection for pair
// - Classify block type from control byte
// - Info block: sequence bit7, chain bit6
// - Receive-ready: 100, expected seq, code
// - Supervisory: 11, request bit, function
// - Function codes zero to three valid
// - Bit six: request zero, response one
// - Count equals payload length, FF reserved
// - Info carries data, receive-ready none
// - Size and wait carry one byte
// - Append check byte, receiver verifies
// - Opposite-direction guard of 22 etu
// - In-frame gap at most 11+2^n etu
// - Card payload limit defaults to 32
module bfc_codec #(
    parameter logic [15:0] CYC_PER_ETU = 16'h0174
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Received character stream from the line.
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    // Transmit character stream to the line.
    input wire logic tx_ready,
    input wire logic [7:0] tx_pay_byte,
    output logic tx_pay_take,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    // Frame results.
    output logic rx_done,
    output logic rx_bad,
    output logic [3:0] rx_err_code
);
    // ****************************************
    // Helper functions.
    // ****************************************
    function automatic bfc_pkg::bfc_blk_type bfc_classify(input logic [7:0] c);
        if (!c[7]) begin
            bfc_classify = bfc_pkg::BFC_BLK_INFO;
        end else if (c[7:5] == 3'b100) begin
            bfc_classify = bfc_pkg::BFC_BLK_RR;
        end else if (c[7:6] == 2'b11) begin
            bfc_classify = bfc_pkg::BFC_BLK_SUP;
        end else begin
            bfc_classify = bfc_pkg::BFC_BLK_BAD;
        end
    endfunction

    // Checks control byte codes and payload length against block type.
    function automatic logic bfc_ctrl_ok(input logic [7:0] c, input logic [7:0] len);
        logic ok;
        ok = 1'b0;
        unique case (bfc_classify(c))
            bfc_pkg::BFC_BLK_INFO: ok = (c[4:0] == 5'h00);
            bfc_pkg::BFC_BLK_RR: ok = (c[3:0] <= `BFC_RERR_OTHER) && (len == `BFC_LEN_NONE);
            bfc_pkg::BFC_BLK_SUP: begin
                if (c[4:0] == `BFC_SFN_SIZE || c[4:0] == `BFC_SFN_WAIT) begin
                    ok = (len == 8'h01);
                end else if (c[4:0] == `BFC_SFN_RESYNC || c[4:0] == `BFC_SFN_ABORT) begin
                    ok = (len == `BFC_LEN_NONE);
                end else begin
                    ok = 1'b0;
                end
            end
            bfc_pkg::BFC_BLK_BAD: ok = 1'b0;
        endcase
        bfc_ctrl_ok = ok;
    endfunction

    function automatic logic [7:0] bfc_node(input logic [2:0] tgt, input logic [2:0] src);
        bfc_node = {1'b0, tgt, 1'b0, src};
    endfunction

    // ****************************************
    // Registers.
    // ****************************************
    logic [7:0] tx_ctrl_r;
    logic [7:0] tx_len_r;
    logic [7:0] opt_r;
    logic [7:0] card_max_r;
    logic [2:0] wait_int_r;
    logic tx_go;
    logic tx_busy_r;
    logic conn_open_r;
    logic [5:0] conn_pair_r;
    logic [7:0] rx_node_r;
    logic [7:0] rx_ctrl_r;
    logic [7:0] rx_len_r;
    logic [7:0] rx_sum_r;
    logic gap_err_r;
    logic guard_err_r;
    logic [7:0] etu_count;
    logic last_rx_r;
    logic timer_restart;

    assign tx_go = reg_wr && (reg_addr == `BFC_REG_TXHDR) && !tx_busy_r;

    // Configuration writes; count above 254 is clamped so FF is never sent.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_ctrl_r <= 8'h00;
            tx_len_r <= 8'h00;
            opt_r <= `BFC_OPT_XOR_SEL;
            card_max_r <= `BFC_CARD_RX_MAX_DEF;
            wait_int_r <= 3'h4;
        end else if (reg_wr) begin
            if (reg_addr == `BFC_REG_CTRL) begin
                opt_r <= reg_wdata[7:0] & 8'h00;
                card_max_r <= reg_wdata[15:8];
                wait_int_r <= (reg_wdata[18:16] > 3'h5) ? 3'h5 : reg_wdata[18:16];
            end else if (tx_go) begin
                tx_ctrl_r <= reg_wdata[7:0];
                tx_len_r <= (reg_wdata[15:8] > `BFC_MAX_PAYLOAD) ?
                    `BFC_MAX_PAYLOAD : reg_wdata[15:8];
            end
        end
    end

    // ****************************************
    // Transmit framer.
    // ****************************************
    bfc_pkg::bfc_st_type tx_st_r;
    logic [7:0] tx_cnt_r;
    logic [7:0] tx_sum_r;
    logic tx_fire;
    logic [7:0] tx_cur;
    logic guard_ok;

    assign guard_ok = !last_rx_r || (etu_count >= 8'(`BFC_GUARD_ETU));
    assign tx_fire = tx_busy_r && tx_ready && guard_ok && !tx_valid;

    // Byte order node, control, count, payload, check; header always sent.
    always_comb begin
        unique case (tx_st_r)
            bfc_pkg::BFC_ST_NODE: tx_cur = bfc_node(`BFC_NODE_TGT_DEF, `BFC_NODE_SRC_DEF);
            bfc_pkg::BFC_ST_CTRL: tx_cur = tx_ctrl_r;
            bfc_pkg::BFC_ST_LEN: tx_cur = tx_len_r;
            bfc_pkg::BFC_ST_DATA: tx_cur = tx_pay_byte;
            default: tx_cur = tx_sum_r;
        endcase
    end

    // Transmit sequencer; one byte per handshake with the character layer.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_st_r <= bfc_pkg::BFC_ST_NODE;
            tx_busy_r <= 1'b0;
            tx_cnt_r <= 8'h00;
            tx_sum_r <= 8'h00;
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
            tx_pay_take <= 1'b0;
        end else begin
            tx_valid <= tx_fire;
            tx_pay_take <= tx_fire && (tx_st_r == bfc_pkg::BFC_ST_DATA);
            if (tx_go) begin
                tx_busy_r <= 1'b1;
                tx_st_r <= bfc_pkg::BFC_ST_NODE;
                tx_sum_r <= 8'h00;
            end else if (tx_fire) begin
                tx_byte <= tx_cur;
                tx_sum_r <= tx_sum_r ^ tx_cur;
                unique case (tx_st_r)
                    bfc_pkg::BFC_ST_NODE: tx_st_r <= bfc_pkg::BFC_ST_CTRL;
                    bfc_pkg::BFC_ST_CTRL: tx_st_r <= bfc_pkg::BFC_ST_LEN;
                    bfc_pkg::BFC_ST_LEN: begin
                        tx_cnt_r <= tx_len_r;
                        tx_st_r <= (tx_len_r == `BFC_LEN_NONE) ?
                            bfc_pkg::BFC_ST_CHECK : bfc_pkg::BFC_ST_DATA;
                    end
                    bfc_pkg::BFC_ST_DATA: begin
                        tx_cnt_r <= tx_cnt_r - 8'h01;
                        if (tx_cnt_r == 8'h01) begin
                            tx_st_r <= bfc_pkg::BFC_ST_CHECK;
                        end
                    end
                    default: begin
                        tx_st_r <= bfc_pkg::BFC_ST_NODE;
                        tx_busy_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Receive parser.
    // ****************************************
    bfc_pkg::bfc_st_type rx_st_r;
    logic [7:0] rx_cnt_r;
    logic [7:0] gap_limit;

    assign gap_limit = 8'(`BFC_GAP_BASE_ETU) + (8'h01 << wait_int_r);
    assign timer_restart = rx_valid || tx_fire;

    // Etu timer measures time since the last character in either direction.
    bfc_etu_timer #(.CYC_PER_ETU(CYC_PER_ETU)) bfc_etu_timer_inst (
        .sys_clk(sys_clk),
        .srst(srst),
        .restart(timer_restart),
        .etu_count(etu_count)
    );

    // Direction of the last character, for the turnaround guard.
    // Reset counts as a receive, so the peer's first character raises no false guard error.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            last_rx_r <= 1'b1;
        end else if (rx_valid) begin
            last_rx_r <= 1'b1;
        end else if (tx_fire) begin
            last_rx_r <= 1'b0;
        end
    end

    // Parser walks the frame; the check byte ends it with a verdict.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_st_r <= bfc_pkg::BFC_ST_NODE;
            rx_cnt_r <= 8'h00;
            rx_node_r <= 8'h00;
            rx_ctrl_r <= 8'h00;
            rx_len_r <= 8'h00;
            rx_sum_r <= 8'h00;
            rx_done <= 1'b0;
            rx_bad <= 1'b0;
            rx_err_code <= `BFC_RERR_OK;
            gap_err_r <= 1'b0;
            conn_open_r <= 1'b0;
            conn_pair_r <= 6'h00;
        end else begin
            rx_done <= 1'b0;
            if (rx_st_r != bfc_pkg::BFC_ST_NODE && etu_count > gap_limit) begin
                // Gap exceeded: frame is dropped and the parser resyncs.
                rx_st_r <= bfc_pkg::BFC_ST_NODE;
                gap_err_r <= 1'b1;
                rx_done <= 1'b1;
                rx_bad <= 1'b1;
                rx_err_code <= `BFC_RERR_OTHER;
            end else if (rx_valid) begin
                rx_sum_r <= (rx_st_r == bfc_pkg::BFC_ST_NODE) ? rx_byte : rx_sum_r ^ rx_byte;
                unique case (rx_st_r)
                    bfc_pkg::BFC_ST_NODE: begin
                        rx_node_r <= rx_byte;
                        gap_err_r <= 1'b0;
                        rx_st_r <= bfc_pkg::BFC_ST_CTRL;
                    end
                    bfc_pkg::BFC_ST_CTRL: begin
                        rx_ctrl_r <= rx_byte;
                        rx_st_r <= bfc_pkg::BFC_ST_LEN;
                    end
                    bfc_pkg::BFC_ST_LEN: begin
                        rx_len_r <= rx_byte;
                        rx_cnt_r <= rx_byte;
                        rx_st_r <= (rx_byte == `BFC_LEN_NONE) ?
                            bfc_pkg::BFC_ST_CHECK : bfc_pkg::BFC_ST_DATA;
                    end
                    bfc_pkg::BFC_ST_DATA: begin
                        rx_cnt_r <= rx_cnt_r - 8'h01;
                        if (rx_cnt_r == 8'h01) begin
                            rx_st_r <= bfc_pkg::BFC_ST_CHECK;
                        end
                    end
                    default: begin
                        rx_st_r <= bfc_pkg::BFC_ST_NODE;
                        rx_done <= 1'b1;
                        if ((rx_sum_r ^ rx_byte) != 8'h00) begin
                            rx_bad <= 1'b1;
                            rx_err_code <= `BFC_RERR_CHECK;
                        end else if (rx_len_r == `BFC_LEN_RSVD ||
                                     !bfc_ctrl_ok(rx_ctrl_r, rx_len_r) ||
                                     rx_node_r != 8'h00 ||
                                     (bfc_classify(rx_ctrl_r) == bfc_pkg::BFC_BLK_INFO &&
                                      rx_len_r > card_max_r)) begin
                            rx_bad <= 1'b1;
                            rx_err_code <= `BFC_RERR_OTHER;
                        end else begin
                            rx_bad <= 1'b0;
                            rx_err_code <= `BFC_RERR_OK;
                            if (!conn_open_r) begin
                                conn_open_r <= 1'b1;
                                conn_pair_r <= {rx_node_r[6:4], rx_node_r[2:0]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Guard violation: peer answered inside the turnaround window.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            guard_err_r <= 1'b0;
        end else if (rx_valid && !last_rx_r) begin
            guard_err_r <= (etu_count < 8'(`BFC_GUARD_ETU));
        end
    end

    // ****************************************
    // Register read port.
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `BFC_REG_CTRL: reg_rdata <= {13'h0000, wait_int_r, card_max_r, opt_r};
                `BFC_REG_TXHDR: reg_rdata <= {16'h0000, tx_len_r, tx_ctrl_r};
                `BFC_REG_STAT: reg_rdata <= {24'h000000, conn_open_r, guard_err_r,
                                             gap_err_r, tx_busy_r, rx_err_code};
                `BFC_REG_RXHDR: reg_rdata <= {8'h00, rx_len_r, rx_ctrl_r, rx_node_r};
                `BFC_REG_RXCHK: reg_rdata <= {22'h000000, bfc_classify(rx_ctrl_r), rx_sum_r};
                `BFC_REG_LINK: reg_rdata <= {26'h0000000, conn_pair_r};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Checks.
    // ****************************************
    property p_node_zero;
        @(posedge sys_clk) disable iff (srst)
        (tx_fire && tx_st_r == bfc_pkg::BFC_ST_NODE) |=> (tx_byte == 8'h00);
    endproperty
    a_node_zero: assert property (p_node_zero) else $error("node byte not zero");

    property p_no_ff_len;
        @(posedge sys_clk) disable iff (srst)
        (tx_fire && tx_st_r == bfc_pkg::BFC_ST_LEN) |=> (tx_byte != 8'hff);
    endproperty
    a_no_ff_len: assert property (p_no_ff_len) else $error("reserved count sent");

    property p_check_xor;
        @(posedge sys_clk) disable iff (srst)
        (tx_fire && tx_st_r == bfc_pkg::BFC_ST_CHECK) |=> (tx_byte == $past(tx_sum_r));
    endproperty
    a_check_xor: assert property (p_check_xor) else $error("check byte wrong");

    property p_guard;
        @(posedge sys_clk) disable iff (srst)
        (tx_fire && last_rx_r) |-> (etu_count >= 8'(`BFC_GUARD_ETU));
    endproperty
    a_guard: assert property (p_guard) else $error("guard time broken");

    property p_bad_code;
        @(posedge sys_clk) disable iff (srst)
        (rx_done && rx_bad) |-> (rx_err_code == 4'h1 || rx_err_code == 4'h2);
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad frame code");

    property p_ok_code;
        @(posedge sys_clk) disable iff (srst)
        (rx_done && !rx_bad) |-> (rx_err_code == 4'h0);
    endproperty
    a_ok_code: assert property (p_ok_code) else $error("good frame code");

    property p_opt;
        @(posedge sys_clk) disable iff (srst)
        reg_wr |=> (opt_r == 8'h00);
    endproperty
    a_opt: assert property (p_opt) else $error("option byte nonzero");

    property p_hdr_order;
        @(posedge sys_clk) disable iff (srst)
        (tx_fire && tx_st_r == bfc_pkg::BFC_ST_NODE) |=>
            (tx_st_r == bfc_pkg::BFC_ST_CTRL && tx_busy_r);
    endproperty
    a_hdr_order: assert property (p_hdr_order) else $error("header order");
endmodule
`default_nettype wire

//--- bfc_codec_tb.sv
`default_nettype none
`include "bfc_map.svh"
`define CHK(got, exp, msg) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
    end \
end
// ****************************************
// Self-checking bench for the frame codec.
// ****************************************
module bfc_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_ready;
    logic [7:0] pay_idx = 8'h00;
    logic [7:0] tx_pay_byte;
    logic tx_pay_take, tx_valid, rx_done, rx_bad;
    logic [7:0] tx_byte;
    logic [3:0] rx_err_code;
    logic [31:0] d;
    int n_mismatch = 0;
    int checks = 0;
    int n0;
    // Clock of 8 ns.
    always #4 sys_clk = ~sys_clk;
    // Payload source advances only when the codec takes a byte.
    assign tx_pay_byte = pay_idx ^ 8'h5a;
    always @(posedge sys_clk) begin
        if (tx_pay_take) begin
            pay_idx <= pay_idx + 8'h01;
        end
    end
    // Etu shortened to four cycles so guard and gap limits stay short.
    bfc_codec #(.CYC_PER_ETU(16'h0004)) bfc_codec_inst (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_pay_byte(tx_pay_byte),
        .tx_pay_take(tx_pay_take), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .rx_done(rx_done), .rx_bad(rx_bad), .rx_err_code(rx_err_code)
    );
    bfc_peer bfc_peer_inst (
        .sys_clk(sys_clk), .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_done(rx_done),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready)
    );
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    task automatic wait_done(input int n);
        for (int i = 0; i < 400 && bfc_peer_inst.n_done == n; i++) @(posedge sys_clk);
        if (bfc_peer_inst.n_done == n) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t no frame end", $time);
            summarize();
        end
    endtask
    // Builds a frame with its xor check byte, optionally spoiled, and checks the verdict.
    task automatic rx_case(input logic [7:0] node, input logic [7:0] ctrl, input logic [7:0] len,
                           input logic spoil, input logic [3:0] code,
                           input bfc_pkg::bfc_blk_type typ);
        logic [7:0] q[$];
        logic [7:0] x;
        logic [31:0] v;
        int n;
        q = {node, ctrl, len};
        for (int k = 0; k < len; k++) q.push_back(8'(k) ^ 8'h33);
        x = 8'h00;
        foreach (q[k]) x ^= q[k];
        q.push_back(x ^ {7'h0, spoil});
        n = bfc_peer_inst.n_done;
        bfc_peer_inst.send_frame(q);
        wait_done(n);
        `CHK(rx_bad, (code != `BFC_RERR_OK), "rx bad")
        `CHK(rx_err_code, code, "rx code")
        if (code == `BFC_RERR_OK) begin
            rd(`BFC_REG_RXCHK, v);
            `CHK(v[9:8], typ, "block type")
            `CHK(v[7:0], 8'h00, "rx xor")
        end
        $display("rx test ctrl %0h done", ctrl);
    endtask
    // Sends one frame and compares every line byte, a refused header write included.
    task automatic tx_case(input logic [7:0] ctrl, input logic [7:0] len);
        logic [7:0] e[$];
        logic [7:0] x;
        logic [7:0] b;
        logic [31:0] v;
        int n;
        n = (len > `BFC_MAX_PAYLOAD) ? 254 : int'(len);
        bfc_peer_inst.txq.delete();
        // Payload source runs on from the last frame; expect from where it stands.
        b = pay_idx;
        wr(`BFC_REG_TXHDR, {16'h0, len, ctrl});
        rd(`BFC_REG_STAT, v);
        `CHK(v[4], 1'b1, "busy")
        wr(`BFC_REG_TXHDR, 32'h0000_00ff);
        for (int i = 0; i < 3000 && bfc_peer_inst.txq.size() < n + 4; i++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        `CHK(bfc_peer_inst.txq.size(), n + 4, "tx count")
        e = {8'h00, ctrl, 8'(n)};
        for (int k = 0; k < n; k++) e.push_back(8'(b + 8'(k)) ^ 8'h5a);
        x = 8'h00;
        foreach (e[k]) x ^= e[k];
        e.push_back(x);
        for (int k = 0; k < e.size() && k < bfc_peer_inst.txq.size(); k++) begin
            `CHK(bfc_peer_inst.txq[k], e[k], "tx byte")
        end
        $display("tx test len %0d done", n);
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`BFC_REG_CTRL, d);
        `CHK(d, 32'h0004_2000, "ctrl reset")
        rd(`BFC_REG_STAT, d);
        `CHK(d, 32'h0, "stat reset")
        rd(8'h18, d);
        `CHK(d, 32'h0, "unmapped")
        wr(`BFC_REG_CTRL, 32'h0007_20ff);
        rd(`BFC_REG_CTRL, d);
        `CHK(d, 32'h0005_2000, "ctrl clamp")
        wr(`BFC_REG_CTRL, 32'h0004_2000);
        $display("register test done");
        rx_case(8'h00, 8'h00, 8'h02, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_INFO);
        rx_case(8'h00, 8'h60, 8'h20, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_INFO);
        rx_case(8'h00, 8'h90, 8'h00, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_RR);
        rx_case(8'h00, 8'h82, 8'h00, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_RR);
        rx_case(8'h00, 8'hc1, 8'h01, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'he3, 8'h01, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'hc0, 8'h00, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'he2, 8'h00, 1'b0, `BFC_RERR_OK, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'h00, 8'h01, 1'b1, `BFC_RERR_CHECK, bfc_pkg::BFC_BLK_INFO);
        rx_case(8'h12, 8'h00, 8'h00, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_INFO);
        rx_case(8'h00, 8'h85, 8'h00, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_RR);
        rx_case(8'h00, 8'hc5, 8'h00, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'hc1, 8'h00, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_SUP);
        rx_case(8'h00, 8'h80, 8'h01, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_RR);
        rx_case(8'h00, 8'h01, 8'h00, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_INFO);
        // A frame cut short after two characters must end by the gap limit of 27 etu.
        n0 = bfc_peer_inst.n_done;
        bfc_peer_inst.send_frame({8'h00, 8'h00});
        wait_done(n0);
        `CHK(rx_bad, 1'b1, "gap bad")
        `CHK(rx_err_code, `BFC_RERR_OTHER, "gap code")
        rd(`BFC_REG_STAT, d);
        `CHK(d[5], 1'b1, "gap flag")
        rx_case(8'h00, 8'h00, 8'h21, 1'b0, `BFC_RERR_OTHER, bfc_pkg::BFC_BLK_INFO);
        // The reply is asked for at once, so it must wait out the 22 etu turnaround.
        tx_case(8'h40, 8'h02);
        `CHK(bfc_peer_inst.first_tx_cyc - bfc_peer_inst.last_rx_cyc >= 87, 1'b1, "guard")
        rd(`BFC_REG_STAT, d);
        `CHK(d[7], 1'b1, "connection open")
        `CHK(d[6], 1'b0, "no guard error")
        rd(`BFC_REG_LINK, d);
        `CHK(d, 32'h0, "link pair")
        tx_case(8'hc1, 8'h00);
        bfc_peer_inst.stall = 1'b1;
        tx_case(8'h00, 8'hff);
        summarize();
    end
endmodule
`default_nettype wire

//--- bfc_etu_timer.sv
`default_nettype none
`include "bfc_map.svh"
// ****************************************
// Counts etu ticks since the last restart and reports the count.
// ****************************************
module bfc_etu_timer #(
    parameter logic [15:0] CYC_PER_ETU = 16'h0174
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Control.
    input wire logic restart,
    // Count of whole etu elapsed, saturating.
    output logic [7:0] etu_count
);
    logic [15:0] cyc_r;

    // Prescaler restarts with each character so counts align to leading edges.
    always_ff @(posedge sys_clk) begin
        if (srst || restart) begin
            cyc_r <= 16'h0000;
            etu_count <= 8'h00;
        end else if (cyc_r == CYC_PER_ETU - 16'h0001) begin
            cyc_r <= 16'h0000;
            if (etu_count != 8'hff) begin
                etu_count <= etu_count + 8'h01;
            end
        end else begin
            cyc_r <= cyc_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- bfc_map.svh
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH
// ****************************************
// Frame field positions and codes.
// ****************************************
`define BFC_NODE_TGT_HI 7
`define BFC_NODE_TGT_LO 5
`define BFC_NODE_SRC_HI 3
`define BFC_NODE_SRC_LO 1
`define BFC_NODE_TGT_DEF 3'h0
`define BFC_NODE_SRC_DEF 3'h0
`define BFC_OPT_XOR_SEL 8'h00
`define BFC_LEN_NONE 8'h00
`define BFC_LEN_RSVD 8'hff
`define BFC_MAX_PAYLOAD 8'hfe
`define BFC_CARD_RX_MAX_DEF 8'h20
`define BFC_RERR_OK 4'h0
`define BFC_RERR_CHECK 4'h1
`define BFC_RERR_OTHER 4'h2
`define BFC_SFN_RESYNC 5'h00
`define BFC_SFN_SIZE 5'h01
`define BFC_SFN_ABORT 5'h02
`define BFC_SFN_WAIT 5'h03
`define BFC_SFN_VPP 5'h04
// ****************************************
// Register offsets (byte addresses).
// ****************************************
`define BFC_REG_CTRL 8'h00
`define BFC_REG_TXHDR 8'h04
`define BFC_REG_STAT 8'h08
`define BFC_REG_RXHDR 8'h0c
`define BFC_REG_RXCHK 8'h10
`define BFC_REG_LINK 8'h14
// ****************************************
// Timing.
// ****************************************
`define BFC_CLK_MHZ 125
`define BFC_ETU_NS_DEF 32'd2976
`define BFC_GUARD_ETU 22
`define BFC_GAP_BASE_ETU 11
`endif

//--- bfc_peer.sv
`default_nettype none
// ****************************************
// Line peer that feeds frames to the codec and collects its bytes.
// ****************************************
module bfc_peer (
    // Clock.
    input wire logic sys_clk,
    // Codec outputs watched.
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic rx_done,
    // Line side driven into the codec.
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    int cyc = 0;
    int last_rx_cyc = 0;
    int first_tx_cyc = 0;
    int n_done = 0;
    logic [7:0] txq[$];
    // Line idles at zero before the first character.
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b1;
    end
    // A stalling peer drops ready three cycles in eight, as a slow character layer would.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        tx_ready <= !(stall && (cyc % 8 < 3));
        if (rx_done) begin
            n_done <= n_done + 1;
        end
        if (tx_valid) begin
            if (txq.size() == 0) begin
                first_tx_cyc <= cyc;
            end
            txq.push_back(tx_byte);
        end
    end
    // Sends characters in order, one every four cycles, well inside the gap limit.
    task automatic send_frame(input logic [7:0] q[$]);
        foreach (q[k]) begin
            @(posedge sys_clk);
            rx_valid <= 1'b1;
            rx_byte <= q[k];
            last_rx_cyc = cyc;
            @(posedge sys_clk);
            rx_valid <= 1'b0;
            // The held byte is stale now, so show its inverse rather than a lucky match.
            rx_byte <= ~q[k];
            repeat (2) @(posedge sys_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- bfc_pkg.sv
`default_nettype none
package bfc_pkg;
    // ****************************************
    // Block types and parser states.
    // ****************************************
    typedef enum logic [1:0] {
        BFC_BLK_INFO = 2'b00,
        BFC_BLK_RR = 2'b01,
        BFC_BLK_SUP = 2'b10,
        BFC_BLK_BAD = 2'b11
    } bfc_blk_type;
    typedef enum logic [2:0] {
        BFC_ST_NODE = 3'b000,
        BFC_ST_CTRL = 3'b001,
        BFC_ST_LEN = 3'b010,
        BFC_ST_DATA = 3'b011,
        BFC_ST_CHECK = 3'b100
    } bfc_st_type;
endpackage
`default_nettype wire
